//--- rtl/osp_addr_select.sv
// address select, strap capture, baud ticks and event flags of the octal serial board
`timescale 1ns/1ps
module osp_addr_select import osp_pkg::*; #(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  // cpu i/o port cycle
  input  wire logic [ADDR_W-1:0]                 io_addr,
  input  wire logic                              io_wr,
  input  wire logic                              io_rd,
  output      logic [DATA_W-1:0]                 io_rd_data,
  output      logic                              io_rd_hit,
  // serial channel side
  output      logic [NUM_CH-1:0]                 chan_cs,
  output      logic                              chan_is_data,
  output      logic                              chan_wr,
  output      logic                              chan_rd,
  input  wire logic [NUM_CH-1:0][DATA_W-1:0]     chan_rdata,
  output      logic [NUM_CH-1:0]                 baud_tick,
  output      logic                              ch8_sync_txc,
  output      logic                              ch8_sync_rxc,
  // timer side
  output      logic                              timer_cs,
  output      logic                              timer_is_data,
  input  wire logic [DATA_W-1:0]                 timer_rdata,
  input  wire logic                              timer_irq,
  output      logic                              timer_irq_cpu,
  // straps and pins
  input  wire logic                              base_select_bit_high,
  input  wire logic                              base_select_bit_mid,
  input  wire logic                              base_select_bit_low,
  input  wire logic                              timer_access_strap,
  input  wire logic                              port_order_strap,
  input  wire logic [NUM_CH-1:0][BAUD_SEL_W-1:0] baud_strap,
  input  wire logic                              sync_transmit_clock,
  input  wire logic                              sync_receive_clock,
  // software register port
  input  wire logic [1:0]                        reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_we,
  input  wire logic                              reg_re,
  output      logic [7:0]                        reg_rdata,
  output      logic                              irq
);

  osp_state_t  st_reg;
  osp_state_t  st_next;
  osp_straps_t pins;

  // raw pin bundle in the same layout as the captured straps
  always_comb begin
    pins.baud_sel = baud_strap;
    pins.sync_rxc = sync_receive_clock;
    pins.sync_txc = sync_transmit_clock;
    pins.swap     = port_order_strap;
    pins.timer_en = timer_access_strap;
    pins.base_sel = {base_select_bit_high, base_select_bit_mid, base_select_bit_low};
  end

  // decode terms, all on the live cpu address
  logic        access;
  logic        blk_hit;
  logic [4:0]  ofs;
  logic        ch_hit;
  logic        tmr_pair;
  logic        tmr_hit;
  logic        refused;
  logic        unmapped;
  logic [2:0]  ch_idx;
  logic [7:0]  events;
  logic [7:0]  w1c;

  // upper three bits against the base, lower five pick the port
  always_comb begin
    access   = io_wr | io_rd;
    blk_hit  = io_addr[ADDR_W-1 -: 3] == st_reg.straps.base_sel;
    ofs      = io_addr[4:0];
    ch_hit   = blk_hit && !ofs[4];
    tmr_pair = blk_hit && (ofs[4:1] == TIMER_PAIR);
    tmr_hit  = tmr_pair && st_reg.straps.timer_en;
    refused  = access && tmr_pair && !st_reg.straps.timer_en;
    unmapped = access && blk_hit && (ofs > LAST_MAPPED);
    ch_idx   = ofs[3:1];
  end

  // channel and timer selects are combinational so the target sees them in-cycle
  always_comb begin
    chan_cs = '0;
    if (access && ch_hit) begin
      chan_cs[ch_idx] = 1'b1;
    end
    chan_is_data  = ofs[0] ^ st_reg.straps.swap;
    timer_cs      = access && tmr_hit;
    timer_is_data = ofs[0];
    chan_wr       = io_wr && ch_hit;
    chan_rd       = io_rd && ch_hit;
  end

  // events that software can watch; timer irq counts on its rising edge
  always_comb begin
    events                   = '0;
    events[EV_TIMER_REFUSED] = refused;
    events[EV_UNMAPPED]      = unmapped;
    events[EV_TIMER_IRQ]     = timer_irq && !st_reg.timer_irq_q;
    w1c                      = '0;
    if (reg_we && reg_addr == REG_STATUS) begin
      w1c = reg_wdata;
    end
  end

  // next state: straps, read path, registers
  always_comb begin
    st_next = st_reg;

    // three-stage capture; a strap moves once stages two and three agree
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < STRAP_W; i++) begin
      if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        st_next.straps[i] = st_reg.sync3[i];
      end
    end

    // cpu read data stands in the cycle after the strobe only
    st_next.rd_data = RD_IDLE;
    st_next.rd_hit  = 1'b0;
    if (io_rd && ch_hit) begin
      st_next.rd_data = chan_rdata[ch_idx];
      st_next.rd_hit  = 1'b1;
    end else if (io_rd && tmr_hit) begin
      st_next.rd_data = timer_rdata;
      st_next.rd_hit  = 1'b1;
    end

    // timer interrupt is forwarded whatever the decode says
    st_next.timer_irq_q = timer_irq;

    // sticky events: a new event beats a same-cycle clear
    st_next.status = (st_reg.status & ~w1c) | events;
    if (reg_we && reg_addr == REG_MASK) begin
      st_next.mask = reg_wdata;
    end

    // register read answer, unmapped offset reads zero
    st_next.reg_rdata = '0;
    if (reg_re) begin
      case (reg_addr)
        REG_STATUS: st_next.reg_rdata = st_reg.status;
        REG_MASK:   st_next.reg_rdata = st_reg.mask;
        REG_STRAPS: st_next.reg_rdata = {1'b0,
                                         st_reg.straps.sync_rxc,
                                         st_reg.straps.sync_txc,
                                         st_reg.straps.swap,
                                         st_reg.straps.timer_en,
                                         st_reg.straps.base_sel};
        default:    st_next.reg_rdata = '0;
      endcase
    end
  end

  // single state register; straps start at zero until captured
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.status <= STATUS_RST;
      st_reg.mask   <= MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // one rate generator per channel, each on its own strap
  for (genvar c = 0; c < NUM_CH; c++) begin : g_baud
    osp_baud_gen #(
      .CLK_HZ (CLK_HZ)
    ) u_baud (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .rate_sel (st_reg.straps.baud_sel[c]),
      .tick     (baud_tick[c])
    );
  end

  // outputs from state
  assign io_rd_data    = st_reg.rd_data;
  assign io_rd_hit     = st_reg.rd_hit;
  assign timer_irq_cpu = st_reg.timer_irq_q;
  assign reg_rdata     = st_reg.reg_rdata;
  assign irq           = |(st_reg.status & st_reg.mask);
  // only the last channel is offered the modem clocks; the rest stay async
  assign ch8_sync_txc  = st_reg.straps.sync_txc;
  assign ch8_sync_rxc  = st_reg.straps.sync_rxc;

  // checks on the decoder
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // six steady samples cover three flops, the agree stage and the first edge out of reset
  sequence s_base_pins_steady;
    $stable(pins.base_sel) [*6];
  endsequence

  sequence s_chan_read;
    io_rd && chan_cs != '0;
  endsequence

  property p_strap_follows;
    s_base_pins_steady |-> st_reg.straps.base_sel == pins.base_sel;
  endproperty

  property p_chan_read_data;
    logic [DATA_W-1:0] d;
    (s_chan_read, d = chan_rdata[io_addr[3:1]]) |=> io_rd_data == d && io_rd_hit;
  endproperty

  a_outside_block: assert property (
    access && io_addr[7:5] != st_reg.straps.base_sel |-> chan_cs == '0 && !timer_cs)
    else $error("select outside the decoded block");

  a_strap_capture: assert property (p_strap_follows)
    else $error("base strap not captured after settling");

  a_chan_pair: assert property (
    chan_cs != '0 |-> !io_addr[4] && chan_cs == (8'h01 << io_addr[3:1]))
    else $error("channel select does not match address pair");

  a_timer_pair: assert property (
    access && io_addr[7:5] == st_reg.straps.base_sel && io_addr[4:1] == TIMER_PAIR
      && st_reg.straps.timer_en |-> timer_cs)
    else $error("enabled timer pair not selected");

  a_timer_gated: assert property (
    !st_reg.straps.timer_en |-> !timer_cs ##1 !io_rd_hit || $past(chan_cs) != '0)
    else $error("timer reached while not decoded");

  a_timer_irq_pass: assert property (
    $rose(timer_irq) |=> timer_irq_cpu ##1 st_reg.status[EV_TIMER_IRQ])
    else $error("timer interrupt not forwarded");

  a_order_normal: assert property (
    chan_cs != '0 && !st_reg.straps.swap |-> chan_is_data == io_addr[0])
    else $error("normal order broken");

  a_order_swap: assert property (
    chan_cs != '0 && st_reg.straps.swap |-> chan_is_data == !io_addr[0])
    else $error("swapped order broken");

  a_timer_no_swap: assert property (
    timer_cs |-> timer_is_data == io_addr[0])
    else $error("timer pair order changed by swap");

  a_read_path: assert property (p_chan_read_data)
    else $error("channel read data not returned next cycle");

  a_event_sticky: assert property (
    unmapped |=> st_reg.status[EV_UNMAPPED] ##1 (st_reg.status[EV_UNMAPPED]
      || $past(w1c[EV_UNMAPPED])))
    else $error("unmapped access flag lost");

  a_sync_clock_route: assert property (
    $stable(pins.sync_txc) [*6] |-> ch8_sync_txc == pins.sync_txc)
    else $error("sync transmit clock not routed to channel eight");

  a_sync_rx_route: assert property (
    $stable(pins.sync_rxc) [*6] |-> ch8_sync_rxc == pins.sync_rxc)
    else $error("sync receive clock not routed to channel eight");

  // rate straps are nonzero straight out of reset on most boards
  a_rate_capture: assert property (
    $stable(pins.baud_sel) [*6] |-> st_reg.straps.baud_sel == pins.baud_sel)
    else $error("baud strap not captured after settling");

  a_order_capture: assert property (
    $stable({pins.swap, pins.timer_en}) [*6]
      |-> {st_reg.straps.swap, st_reg.straps.timer_en} == {pins.swap, pins.timer_en})
    else $error("order or timer strap not captured after settling");

  // miss paths, refusal and where a read hit may come from
  sequence s_timer_read;
    io_rd && timer_cs;
  endsequence

  sequence s_refused_access;
    access && tmr_pair && !st_reg.straps.timer_en;
  endsequence

  sequence s_unmapped_access;
    access && blk_hit && ofs > LAST_MAPPED;
  endsequence

  sequence s_missed_read;
    io_rd && chan_cs == '0 && !timer_cs;
  endsequence

  property p_timer_read_data;
    logic [DATA_W-1:0] d;
    (s_timer_read, d = timer_rdata) |=> io_rd_data == d && io_rd_hit;
  endproperty

  a_timer_read: assert property (p_timer_read_data)
    else $error("timer read data not returned next cycle");

  // a refused timer access leaves no trace but the status flag
  a_refused_flag: assert property (
    s_refused_access |-> !timer_cs ##1 st_reg.status[EV_TIMER_REFUSED] && !io_rd_hit)
    else $error("refused timer access not flagged or answered");

  a_unmapped_quiet: assert property (
    s_unmapped_access |-> chan_cs == '0 && !timer_cs ##1 !io_rd_hit)
    else $error("unused offset of the block answered");

  a_miss_read_idle: assert property (
    s_missed_read |=> !io_rd_hit && io_rd_data == RD_IDLE)
    else $error("unselected read returned data");

  a_select_needs_strobe: assert property (
    !access |-> chan_cs == '0 && !timer_cs && !chan_wr && !chan_rd)
    else $error("select without a cpu strobe");

  a_chan_onehot: assert property (
    $onehot0(chan_cs))
    else $error("more than one channel selected");

  a_chan_strobes: assert property (
    chan_wr || chan_rd |-> chan_cs != '0 && chan_wr == io_wr && chan_rd == io_rd)
    else $error("channel strobe without channel select");

  a_timer_cs_gate: assert property (
    timer_cs |-> st_reg.straps.timer_en && chan_cs == '0)
    else $error("timer selected while not enabled");

  a_upper_compare: assert property (
    chan_cs != '0 || timer_cs |-> access && io_addr[7:5] == st_reg.straps.base_sel)
    else $error("select without a base match");

  // read data stands one cycle only, and only after a decoded read
  a_hit_one_cycle: assert property (
    !io_rd |=> !io_rd_hit)
    else $error("read hit without a read strobe");

  a_hit_source: assert property (
    io_rd_hit |-> $past(chan_cs) != '0 || $past(timer_cs))
    else $error("read hit without a select");

endmodule // osp_addr_select

//--- rtl/osp_pkg.sv
// constants, types and state layouts for the octal serial port address select block
// Notes on behaviour
// - answer only inside one aligned 32-port block
// - three base bits pick block 00h through E0h
// - channel n uses pair at offsets 2n, 2n+1
// - timer pair at 10h, 11h when enabled
// - timer disabled: sixteen ports, timer never reached
// - timer interrupt passes even when not decoded
// - normal order: status even, data odd
// - swapped order: data even, status odd
// - swap affects channels, never the timer pair
// - each channel picks one of eight baud rates
// - channel rate choices are fully independent
// - only channel eight gets sync clock lines
// - sync mode for modems only, others async
package osp_pkg;

  localparam int NUM_CH     = 8;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam int BAUD_SEL_W = 3;
  localparam int CNT_W      = 20;

  // block compare and offset decode
  localparam logic [2:0] BLK_ADDR_MSB  = 3'h7;
  localparam logic [3:0] TIMER_PAIR    = 4'h8;
  localparam logic [4:0] LAST_MAPPED   = 5'h11;

  // timing: clock and oversampling of the serial channels
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ_DEF    = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int OVERSAMPLE    = 16;
  localparam int BAUD_RATE [NUM_CH] = '{110, 134, 300, 1200, 2400, 4800, 9600, 19200};
  localparam int SYNC_STAGES   = 3;

  // software register port
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_MASK   = 2'h1;
  localparam logic [1:0] REG_STRAPS = 2'h2;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] RD_IDLE    = 8'h00;

  // event bits in status and mask
  localparam int EV_TIMER_REFUSED = 0;
  localparam int EV_UNMAPPED      = 1;
  localparam int EV_TIMER_IRQ     = 2;

  typedef struct packed {
    logic [NUM_CH-1:0][BAUD_SEL_W-1:0] baud_sel;
    logic                              sync_rxc;
    logic                              sync_txc;
    logic                              swap;
    logic                              timer_en;
    logic [2:0]                        base_sel;
  } osp_straps_t;

  localparam int STRAP_W = $bits(osp_straps_t);

  typedef struct packed {
    logic [STRAP_W-1:0] sync1;
    logic [STRAP_W-1:0] sync2;
    logic [STRAP_W-1:0] sync3;
    osp_straps_t        straps;
    logic [DATA_W-1:0]  rd_data;
    logic               rd_hit;
    logic [7:0]         status;
    logic [7:0]         mask;
    logic [7:0]         reg_rdata;
    logic               timer_irq_q;
  } osp_state_t;

  typedef struct packed {
    logic [CNT_W-1:0]      cnt;
    logic [BAUD_SEL_W-1:0] sel;
    logic                  tick;
  } osp_baud_state_t;

endpackage

//--- rtl/osp_baud_gen.sv
// one channel's 16x baud tick generator with strap-selected rate
`timescale 1ns/1ps
module osp_baud_gen import osp_pkg::*; #(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [BAUD_SEL_W-1:0] rate_sel,
  output      logic                  tick
);

  // divisor per rate, rounded down, never below one
  function automatic logic [CNT_W-1:0] div_of(input logic [BAUD_SEL_W-1:0] s);
    int d;
    d = CLK_HZ / (OVERSAMPLE * BAUD_RATE[s]);
    if (d < 1) begin
      d = 1;
    end
    return CNT_W'(d);
  endfunction

  osp_baud_state_t st_reg;
  osp_baud_state_t st_next;

  // restart on a rate change so no stale count leaks across
  always_comb begin
    st_next      = st_reg;
    st_next.sel  = rate_sel;
    st_next.tick = 1'b0;
    if (rate_sel != st_reg.sel) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= div_of(st_reg.sel) - CNT_W'(1)) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_cnt_bound: assert property (st_reg.cnt < div_of(st_reg.sel))
    else $error("baud counter beyond divisor");
  a_tick_at_wrap: assert property (st_reg.tick |-> st_reg.cnt == '0)
    else $error("baud tick without counter wrap");
  a_rate_restart: assert property (
    rate_sel != st_reg.sel |=> st_reg.cnt == '0 && !st_reg.tick)
    else $error("baud counter not restarted on rate change");

endmodule // osp_baud_gen

//--- test/osp_cpu_model.sv
// bus master cpu model issuing i/o port cycles
`timescale 1ns/1ps
module osp_cpu_model import osp_pkg::*; (
  input  wire logic              clk_sys,
  output      logic [ADDR_W-1:0] io_addr,
  output      logic              io_wr,
  output      logic              io_rd,
  input  wire logic [DATA_W-1:0] io_rd_data,
  input  wire logic              io_rd_hit
);
  // idle bus before the first cycle
  initial begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end

  // one read; answer taken only in the cycle after the strobe
  task automatic io_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                         output logic h);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    io_addr <= ~a; // released address must not look held
    #1;
    d = io_rd_data;
    h = io_rd_hit;
  endtask

  // one write; the board has no write data path to model
  task automatic io_write(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    io_addr <= a;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_addr <= ~a;
    #1;
  endtask
endmodule // osp_cpu_model

//--- test/osp_addr_select_tb_top.sv
// self-checking testbench of the octal serial port address select block
`timescale 1ns/1ps
module osp_addr_select_tb_top import osp_pkg::*; ();
  localparam int CLKH = 3072000; // shortened dividers
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] io_addr;
  logic io_wr, io_rd, io_rd_hit, chan_is_data, chan_wr, chan_rd, timer_cs, timer_is_data;
  logic [DATA_W-1:0] io_rd_data;
  logic [NUM_CH-1:0] chan_cs, baud_tick;
  logic [NUM_CH-1:0][DATA_W-1:0] chan_rdata;
  logic [DATA_W-1:0] timer_rdata = 8'h5a;
  logic timer_irq = 1'b0;
  logic timer_irq_cpu, ch8_sync_txc, ch8_sync_rxc, irq;
  logic base_select_bit_high = 1'b0;
  logic base_select_bit_mid = 1'b0;
  logic base_select_bit_low = 1'b0;
  logic timer_access_strap = 1'b0;
  logic port_order_strap = 1'b0;
  logic sync_transmit_clock = 1'b0;
  logic sync_receive_clock = 1'b0;
  logic [NUM_CH-1:0][BAUD_SEL_W-1:0] baud_strap = {3'h7, 3'h7, 12'h0, 3'h3, 3'h6};
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] cs_q;
  logic isd_q, tcs_q, tisd_q, wr_q, rd_q;
  int fails = 0;
  int n_tests = 0;

  always #2 clk_sys = ~clk_sys;
  initial for (int i = 0; i < NUM_CH; i++) chan_rdata[i] = 8'h30 + 8'(i);

  osp_addr_select #(.CLK_HZ(CLKH)) osp_addr_select_inst (
    .clk_sys, .rst_n, .io_addr, .io_wr, .io_rd, .io_rd_data, .io_rd_hit,
    .chan_cs, .chan_is_data, .chan_wr, .chan_rd, .chan_rdata, .baud_tick,
    .ch8_sync_txc, .ch8_sync_rxc, .timer_cs, .timer_is_data, .timer_rdata,
    .timer_irq, .timer_irq_cpu, .base_select_bit_high, .base_select_bit_mid,
    .base_select_bit_low, .timer_access_strap, .port_order_strap, .baud_strap,
    .sync_transmit_clock, .sync_receive_clock, .reg_addr, .reg_wdata,
    .reg_we, .reg_re, .reg_rdata, .irq);

  osp_cpu_model osp_cpu_model_inst (
    .clk_sys, .io_addr, .io_wr, .io_rd, .io_rd_data, .io_rd_hit);

  // selects are combinational, so grab them at the edge that takes a strobe
  always @(posedge clk_sys) begin
    if (io_rd | io_wr) begin
      cs_q <= chan_cs;
      isd_q <= chan_is_data;
      tcs_q <= timer_cs;
      tisd_q <= timer_is_data;
      wr_q <= chan_wr;
      rd_q <= chan_rd;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // straps pass a three-flop filter, so allow settling time
  task automatic set_straps(input logic [2:0] b, input logic t, input logic s);
    @(posedge clk_sys);
    {base_select_bit_high, base_select_bit_mid, base_select_bit_low} <= b;
    timer_access_strap <= t;
    port_order_strap <= s;
    repeat (6) @(posedge clk_sys);
  endtask

  // offsets 00h-11h, 1Eh and 1Fh of one block, its neighbour block and one channel write
  task automatic t_decode(input logic [2:0] b, input logic s, input logic t);
    logic [7:0] d;
    logic h;
    logic [4:0] o;
    set_straps(b, t, s);
    for (int i = 0; i < 20; i++) begin
      o = (i < 18) ? 5'(i) : 5'(i + 12);
      osp_cpu_model_inst.io_read({b, o}, d, h);
      if (o < 5'h10) begin
        check(h, 1'b1);
        check(d, 8'h30 + 8'(o[3:1]));
        check(cs_q, 8'h01 << o[3:1]);
        check(isd_q, o[0] ^ s);
        check(rd_q, 1'b1);
      end else if (o < 5'h12 && t) begin
        check(h, 1'b1);
        check(d, 8'h5a);
        check(tcs_q, 1'b1);
        check(tisd_q, o[0]);
      end else begin
        check(h, 1'b0);
        check(d, 8'h00);
        check(cs_q, 8'h00);
        check(tcs_q, 1'b0);
      end
    end
    osp_cpu_model_inst.io_read({b + 3'h1, 5'h00}, d, h);
    check(h, 1'b0);
    osp_cpu_model_inst.io_write({b, 5'h0f});
    check(cs_q, 8'h80);
    check(wr_q, 1'b1);
    check(rd_q, 1'b0);
    $display("decode test done, base %h", b);
  endtask

  // strap readback and the refused and unmapped events with mask and clear
  task automatic t_regs;
    logic [7:0] d;
    logic h;
    set_straps(3'h5, 1'b0, 1'b1);
    reg_read(REG_STRAPS, d);
    check(d, 8'h15);
    reg_read(2'h3, d);
    check(d, 8'h00);
    reg_write(REG_STATUS, 8'hff);
    reg_write(REG_MASK, 8'h01);
    osp_cpu_model_inst.io_read(8'hb0, d, h);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b1);
    osp_cpu_model_inst.io_read(8'hb2, d, h);
    reg_read(REG_STATUS, d);
    check(d, 8'h03);
    reg_write(REG_STATUS, 8'h01);
    @(posedge clk_sys);
    #1;
    check(irq, 1'b0);
    reg_read(REG_STATUS, d);
    check(d, 8'h02);
    $display("register test done");
  endtask

  // timer interrupt passes while its ports are not decoded
  task automatic t_timer_irq;
    logic [7:0] d;
    reg_write(REG_STATUS, 8'hff);
    @(posedge clk_sys);
    timer_irq <= 1'b1;
    #1;
    check(timer_irq_cpu, 1'b0);
    @(posedge clk_sys);
    #1;
    check(timer_irq_cpu, 1'b1);
    reg_read(REG_STATUS, d);
    check(d, 8'h04);
    @(posedge clk_sys);
    timer_irq <= 1'b0;
    $display("timer interrupt test done");
  endtask

  task automatic measure(input int ch, input int exp);
    int n;
    n = 0;
    while (baud_tick[ch] !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (baud_tick[ch] !== 1'b1 && n < 5000);
    check(8'(n), 8'(exp));
  endtask

  task automatic t_baud_sync;
    measure(0, CLKH / (16 * BAUD_RATE[6]));
    measure(1, CLKH / (16 * BAUD_RATE[3]));
    measure(6, CLKH / (16 * BAUD_RATE[7]));
    measure(7, CLKH / (16 * BAUD_RATE[7]));
    @(posedge clk_sys);
    sync_transmit_clock <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    check({ch8_sync_txc, ch8_sync_rxc}, 2'h2);
    @(posedge clk_sys);
    sync_receive_clock <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    check({ch8_sync_txc, ch8_sync_rxc}, 2'h3);
    $display("baud and sync test done");
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_timer_irq();
    for (int b = 0; b < 8; b++) t_decode(3'(b), b[0], b[1]);
    t_baud_sync();
    close_out();
  end

  // hang guard well beyond the seven hundred or so cycles of the run
  initial begin
    #40000; // about fifteen times the expected run length
    fails++;
    $display("watchdog expired");
    close_out();
  end
endmodule // osp_addr_select_tb_top
